// >>> verilog/fdcr_pkg.sv
/*
 * Shared constants and types for the floppy controller rate, handshake and
 * end-status register block. Assumes a 250 MHz system clock and an 8-bit host
 * bus with synchronous chip select, address and active-low strobes.
 */
// Functional notes
// - Write at address 111 latches rate bits.
// - Rate steers clock; switch rates without glitches.
// - Unwritten register gives default 500K MFM rate.
// - Advanced mode: nonzero rate bits select 250K.
// - Basic mode stores bits 0-2; bit2 precomp.
// - Advanced mode: bit 4 disables write precompensation.
// - Advanced mode: bit 2 reads as one.
// - Rate decode: 500K, 300K, 250K, 125K.
// - Main status readable anytime without side effects.
// - Direction and request rise within 12 us.
// - Busy drops within 12 us of last read.
// - Seeking bits per drive; refuse read/write commands.
// - Busy during read/write; no other command accepted.
// - Execution flag only in non-DMA execution phase.
// - Direction bit: one means device to host.
// - Request bit marks data register ready.
// - End code 00 normal, bit 6 abnormal.
// - Seek completion sets end status bit 5.
// - 255 steps without track zero: equipment fault.
// - Not-ready end status bit always zero.
// - End status holds head and unit number.
`default_nettype none
package fdcr_pkg;
	localparam logic [2:0] ADDR_MSR       = 3'h4;
	localparam logic [2:0] ADDR_DATA      = 3'h5;
	localparam logic [2:0] ADDR_RATE_CFG  = 3'h7;
	localparam int         RC_RATE_LO     = 0;
	localparam int         RC_RATE_HI     = 1;
	localparam int         RC_BIT2        = 2;
	localparam int         RC_PRECOMP_ADV = 4;
	localparam logic [7:0] RATE_CFG_RST   = 8'h00;
	localparam int         MSR_BUSY       = 4;
	localparam int         MSR_EXEC       = 5;
	localparam int         MSR_DIR        = 6;
	localparam int         MSR_REQ        = 7;
	localparam logic [1:0] TERM_NORMAL    = 2'h0;
	localparam logic [1:0] TERM_ABNORMAL  = 2'h1;
	localparam logic [4:0] OPC_WRITE_DATA = 5'h05;
	localparam logic [4:0] OPC_READ_DATA  = 5'h06;
	localparam logic [4:0] OPC_WRITE_DEL  = 5'h09;
	localparam logic [4:0] OPC_READ_DEL   = 5'h0C;
	localparam logic [7:0] RECAL_STEP_MAX = 8'hFF;
	localparam int         CLK_PERIOD_NS  = 4;
	localparam int         REF_CLK_DIV    = 32;
	localparam int         REF_CLK_MAX_KHZ = 16000;
	localparam int         HS_MAX_NS      = 12000;
	localparam int         HS_MAX_CYC     = HS_MAX_NS / CLK_PERIOD_NS;
	localparam logic [3:0] HS_LAT_CYC     = 4'h8;
	localparam int         BIT_NS_500K    = 2000;
	localparam int         BIT_NS_300K    = 3333;
	localparam int         BIT_NS_250K    = 4000;
	localparam int         BIT_NS_125K    = 8000;
	localparam logic [11:0] DIV_500K = 12'(BIT_NS_500K / CLK_PERIOD_NS);
	localparam logic [11:0] DIV_300K = 12'(BIT_NS_300K / CLK_PERIOD_NS);
	localparam logic [11:0] DIV_250K = 12'(BIT_NS_250K / CLK_PERIOD_NS);
	localparam logic [11:0] DIV_125K = 12'(BIT_NS_125K / CLK_PERIOD_NS);
	typedef enum logic [3:0] {
		RATE_500K = 4'b0001,
		RATE_300K = 4'b0010,
		RATE_250K = 4'b0100,
		RATE_125K = 4'b1000
	} fdcr_rate_e;
	typedef enum logic [3:0] {
		PH_IDLE   = 4'b0001,
		PH_CMD    = 4'b0010,
		PH_EXEC   = 4'b0100,
		PH_RESULT = 4'b1000
	} fdcr_phase_e;
	typedef struct packed {
		logic       valid;
		logic       first;
		logic [7:0] data;
	} fdcr_byte_s;
	typedef struct packed {
		logic       valid;
		logic       failed;
		logic       seek;
		logic       head;
		logic [1:0] unit;
		logic [2:0] res_count;
	} fdcr_end_s;
	typedef struct packed {
		fdcr_rate_e rate;
		logic       precomp_en;
		logic       cfg_bit2;
	} fdcr_cfg_s;
endpackage
`default_nettype wire

// >>> verilog/fdcr_regs.sv
/*
 * Rate configuration, main handshake status and command end status logic.
 * Assumes the host bus inputs are synchronous to clk_i and that the command
 * core answers each command byte within HS_LAT_CYC cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module fdcr_regs
	import fdcr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       cs_n_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	input  wire logic       adv_mode_i,
	input  wire logic       dma_mode_i,
	input  wire logic [3:0] drive_seeking_i,
	input  wire logic       cmd_last_i,
	input  wire logic       exec_req_i,
	input  wire logic       exec_dir_i,
	input  wire fdcr_end_s  end_i,
	input  wire logic [7:0] res_data_i,
	input  wire logic       recal_active_i,
	input  wire logic       step_pulse_i,
	input  wire logic       track0_i,
	output fdcr_byte_s      byte_o,
	output logic            res_pop_o,
	output logic            cmd_refused_o,
	output fdcr_cfg_s       cfg_o,
	output logic            bit_tick_o
);
	logic        rd_n_q;
	logic        wr_n_q;
	logic [1:0]  rate_bits_q;
	logic        cfg_bit2_q;
	logic        precomp_off_adv_q;
	fdcr_phase_e phase_q;
	fdcr_phase_e phase_d;
	logic        host_request_q;
	logic [3:0]  dly_q;
	logic        ctrl_busy_q;
	logic [7:0]  st0_q;
	logic [2:0]  res_count_q;
	logic [2:0]  res_idx_q;
	logic [7:0]  step_cnt_q;
	logic        equipment_fault_q;
	logic        recal_q;
	logic [11:0] div_cnt_q;
	logic [11:0] div_cur_q;
	logic [7:0]  data_q;
	logic        refused_q;
	fdcr_byte_s  byte_q;
	logic        pop_q;

	wire sel       = ~cs_n_i;
	wire rd_fall   = rd_n_q & ~rd_n_i;
	wire wr_fall   = wr_n_q & ~wr_n_i;
	wire rate_wr   = sel & wr_fall & (addr_i == ADDR_RATE_CFG);
	wire data_wr   = sel & wr_fall & (addr_i == ADDR_DATA);
	wire data_rd   = sel & rd_fall & (addr_i == ADDR_DATA);
	wire rd_msr    = sel & ~rd_n_i & (addr_i == ADDR_MSR);
	wire rd_data   = sel & ~rd_n_i & (addr_i == ADDR_DATA);
	// A data read keeps the byte taken on its first edge, since the result index moves on at once.
	wire data_load = ~rd_data | rd_fall;
	wire in_idle   = (phase_q == PH_IDLE);
	wire in_cmd    = (phase_q == PH_CMD);
	wire in_exec   = (phase_q == PH_EXEC);
	wire in_result = (phase_q == PH_RESULT);
	wire [4:0] opc = data_i[4:0];
	wire is_rw     = (opc == OPC_READ_DATA) | (opc == OPC_WRITE_DATA) |
	                 (opc == OPC_READ_DEL) | (opc == OPC_WRITE_DEL);
	wire refuse    = in_idle & data_wr & is_rw & (|drive_seeking_i);
	wire take_cmd  = (in_idle | in_cmd) & data_wr & host_request_q & ~refuse;
	wire take_res  = in_result & data_rd & host_request_q;
	wire last_res  = take_res & (res_idx_q == res_count_q);
	wire dly_done  = (dly_q == 4'h1);

	// Request and direction are the pair the host polls before each byte.
	wire host_request   = in_exec ? exec_req_i : host_request_q;
	wire xfer_direction = in_result | (in_exec & exec_dir_i);
	wire exec_phase_flag = in_exec & ~dma_mode_i;
	wire [7:0] main_handshake_status = {host_request, xfer_direction, exec_phase_flag, ctrl_busy_q, drive_seeking_i};

	// Advanced mode collapses every nonzero setting onto the slow rate.
	wire fdcr_rate_e rate_adv = (rate_bits_q == 2'h0) ? RATE_500K : RATE_250K;
	wire fdcr_rate_e rate_bas = (rate_bits_q == 2'h0) ? RATE_500K :
	                            (rate_bits_q == 2'h1) ? RATE_300K :
	                            (rate_bits_q == 2'h2) ? RATE_250K : RATE_125K;
	wire fdcr_rate_e rate_eff = adv_mode_i ? rate_adv : rate_bas;
	wire [11:0] div_new = (rate_eff == RATE_500K) ? DIV_500K :
	                      (rate_eff == RATE_300K) ? DIV_300K :
	                      (rate_eff == RATE_250K) ? DIV_250K : DIV_125K;
	wire div_wrap = (div_cnt_q == 12'h001);

	wire [7:0] rd_val = (rd_msr | ~in_result) ? main_handshake_status : ((res_idx_q == 3'h0) ? st0_q : res_data_i);

	assign cfg_o.rate       = rate_eff;
	assign cfg_o.precomp_en = adv_mode_i ? ~precomp_off_adv_q : ~cfg_bit2_q;
	assign cfg_o.cfg_bit2   = adv_mode_i ? 1'b1 : cfg_bit2_q;
	assign data_o        = data_q;
	assign data_oe_o     = rd_msr | rd_data;
	assign byte_o        = byte_q;
	assign res_pop_o     = pop_q;
	assign cmd_refused_o = refused_q;
	assign bit_tick_o    = div_wrap;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			data_q <= 8'h00;
		end else begin
			rd_n_q <= rd_n_i;
			wr_n_q <= wr_n_i;
			if (data_load) begin
				data_q <= rd_val;
			end
		end
	end

	// Reserved bits of the active mode are never stored, so writes to them vanish.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rate_bits_q       <= RATE_CFG_RST[1:0];
			cfg_bit2_q        <= RATE_CFG_RST[RC_BIT2];
			precomp_off_adv_q <= RATE_CFG_RST[RC_PRECOMP_ADV];
		end else if (rate_wr) begin
			rate_bits_q <= {data_i[RC_RATE_HI], data_i[RC_RATE_LO]};
			if (adv_mode_i) begin
				precomp_off_adv_q <= data_i[RC_PRECOMP_ADV];
			end else begin
				cfg_bit2_q <= data_i[RC_BIT2];
			end
		end
	end

	// A new divisor is only loaded at the end of a bit cell, so no short cell appears.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt_q <= DIV_500K;
			div_cur_q <= DIV_500K;
		end else if (div_wrap) begin
			div_cnt_q <= div_new;
			div_cur_q <= div_new;
		end else begin
			div_cnt_q <= div_cnt_q - 12'h001;
		end
	end

	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			PH_IDLE: begin
				if (take_cmd) begin
					phase_d = PH_CMD;
				end
			end
			PH_CMD: begin
				if (cmd_last_i) begin
					phase_d = PH_EXEC;
				end
			end
			PH_EXEC: begin
				if (end_i.valid) begin
					phase_d = PH_RESULT;
				end
			end
			PH_RESULT: begin
				if (last_res) begin
					phase_d = PH_IDLE;
				end
			end
			default: phase_d = PH_IDLE;
		endcase
	end

	// Only the idle phase takes a first byte, which blocks commands while busy.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			phase_q <= PH_IDLE;
		end else begin
			phase_q <= phase_d;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			host_request_q <= 1'b1;
			dly_q          <= 4'h0;
		end else if (take_cmd | take_res | refuse) begin
			host_request_q <= 1'b0;
			dly_q          <= HS_LAT_CYC;
		end else if (in_exec | (in_cmd & cmd_last_i)) begin
			host_request_q <= 1'b0;
			dly_q          <= 4'h0;
		end else if (end_i.valid & in_exec) begin
			host_request_q <= 1'b0;
		end else if (dly_q != 4'h0) begin
			dly_q <= dly_q - 4'h1;
			if (dly_done) begin
				host_request_q <= 1'b1;
			end
		end else if (in_result & ~host_request_q) begin
			host_request_q <= 1'b1;
		end
	end

	// Busy clears together with the request after the last result byte.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_busy_q <= 1'b0;
		end else if (in_idle & take_cmd & is_rw) begin
			ctrl_busy_q <= 1'b1;
		end else if (in_idle & dly_done) begin
			ctrl_busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			byte_q    <= '0;
			pop_q     <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			byte_q.valid <= take_cmd | (in_exec & data_wr);
			byte_q.first <= in_idle & take_cmd;
			byte_q.data  <= data_i;
			pop_q        <= take_res & (res_idx_q != 3'h0);
			refused_q    <= refuse;
		end
	end

	// Step counting restarts on every new recalibration.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			recal_q           <= 1'b0;
			step_cnt_q        <= 8'h00;
			equipment_fault_q <= 1'b0;
		end else begin
			recal_q <= recal_active_i;
			if (recal_active_i & ~recal_q) begin
				step_cnt_q        <= 8'h00;
				equipment_fault_q <= 1'b0;
			end else if (recal_active_i & step_pulse_i & ~track0_i & (step_cnt_q != RECAL_STEP_MAX)) begin
				step_cnt_q <= step_cnt_q + 8'h01;
				if (step_cnt_q == RECAL_STEP_MAX - 8'h01) begin
					equipment_fault_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st0_q       <= 8'h00;
			res_count_q <= 3'h0;
			res_idx_q   <= 3'h0;
		end else if (in_exec & end_i.valid) begin
			st0_q[7:6]  <= end_i.failed ? TERM_ABNORMAL : TERM_NORMAL;
			st0_q[5]    <= end_i.seek;
			st0_q[4]    <= equipment_fault_q;
			st0_q[3]    <= 1'b0;
			st0_q[2:0]  <= {end_i.head, end_i.unit};
			res_count_q <= end_i.res_count;
			res_idx_q   <= 3'h0;
		end else if (take_res) begin
			res_idx_q <= res_idx_q + 3'h1;
		end
	end

	property p_rate_capture;
		@(posedge clk_i) disable iff (reset_i)
		rate_wr |=> rate_bits_q == $past(data_i[1:0]);
	endproperty
	a_rate_capture: assert property (p_rate_capture) else $error("rate bits not captured");

	property p_adv_slow;
		@(posedge clk_i) disable iff (reset_i)
		(adv_mode_i && rate_bits_q != 2'h0) |-> cfg_o.rate == RATE_250K;
	endproperty
	a_adv_slow: assert property (p_adv_slow) else $error("advanced rate not 250K");

	property p_switch_at_wrap;
		@(posedge clk_i) disable iff (reset_i)
		!$past(div_wrap) |-> $stable(div_cur_q);
	endproperty
	a_switch_at_wrap: assert property (p_switch_at_wrap) else $error("divisor changed mid cell");

	property p_precomp_basic;
		@(posedge clk_i) disable iff (reset_i)
		!adv_mode_i |-> cfg_o.precomp_en == !cfg_bit2_q && cfg_o.cfg_bit2 == cfg_bit2_q;
	endproperty
	a_precomp_basic: assert property (p_precomp_basic) else $error("basic precomp wrong");

	sequence s_byte_taken;
		take_cmd && !cmd_last_i;
	endsequence
	property p_req_return;
		@(posedge clk_i) disable iff (reset_i)
		s_byte_taken ##1 !cmd_last_i |-> ##[1:9] host_request || in_exec;
	endproperty
	a_req_return: assert property (p_req_return) else $error("request not raised in time");

	property p_exec_flag;
		@(posedge clk_i) disable iff (reset_i)
		main_handshake_status[MSR_EXEC] |-> in_exec && !dma_mode_i;
	endproperty
	a_exec_flag: assert property (p_exec_flag) else $error("exec flag outside exec");

	property p_cmd_dir;
		@(posedge clk_i) disable iff (reset_i)
		(in_idle || in_cmd) |-> !main_handshake_status[MSR_DIR];
	endproperty
	a_cmd_dir: assert property (p_cmd_dir) else $error("direction high in command");

	property p_refuse;
		@(posedge clk_i) disable iff (reset_i)
		refuse |=> cmd_refused_o && !byte_o.valid && in_idle;
	endproperty
	a_refuse: assert property (p_refuse) else $error("seek conflict accepted");

	property p_busy_drop;
		@(posedge clk_i) disable iff (reset_i)
		last_res |-> ##[1:10] !ctrl_busy_q;
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("busy held too long");

	property p_st0_end;
		@(posedge clk_i) disable iff (reset_i)
		(in_exec && end_i.valid) |=> st0_q[3] == 1'b0 && st0_q[2:0] == $past({end_i.head, end_i.unit})
			&& st0_q[7:6] == ($past(end_i.failed) ? TERM_ABNORMAL : TERM_NORMAL);
	endproperty
	a_st0_end: assert property (p_st0_end) else $error("end status wrong");

	property p_msr_quiet;
		@(posedge clk_i) disable iff (reset_i)
		(rd_msr && !rd_data) |=> $stable(phase_q) || $past(cmd_last_i || end_i.valid);
	endproperty
	a_msr_quiet: assert property (p_msr_quiet) else $error("status read disturbed phase");
endmodule
`default_nettype wire

// >>> sim/fdcr_host.sv
/*
 * Host processor model for the rate, handshake and end-status register block.
 * Assumes the device clock and synchronous active-low strobes on the host bus.
 */
`timescale 1ns/1ns
`default_nettype none
module fdcr_host
	import fdcr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic            cs_n,
	output logic [2:0]      addr,
	output logic            rd_n,
	output logic            wr_n,
	output logic [7:0]      wdata,
	output logic            rd_done,
	output logic [7:0]      rd_val,
	output logic            poll_fail
);
	initial begin
		cs_n = 1'b1;
		addr = 3'h0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		wdata = 8'h00;
		rd_done = 1'b0;
		rd_val = 8'h00;
		poll_fail = 1'b0;
	end
	// The released bus shows the inverse of the last byte, so stale data never looks valid.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		addr <= a;
		wdata <= d;
		wr_n <= 1'b0;
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [2:0] a, input logic post, output logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		addr <= a;
		rd_n <= 1'b0;
		repeat (3) @(posedge clk);
		d = rdata;
		rd_val <= rdata;
		rd_done <= post;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge clk);
		rd_done <= 1'b0;
	endtask
	// Polling replaces the fixed wait; 750 polls of 5 cycles bound the wait to 15 us.
	task automatic poll(input logic dir);
		logic [7:0] s;
		int         n;
		n = 0;
		do begin
			rd(ADDR_MSR, 1'b0, s);
			n++;
		end while (!(s[7] === 1'b1 && s[6] === dir) && n < 750);
		if (n >= 750)
			poll_fail <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> sim/fdcr_rate_and_status_regs_tb.sv
/*
 * Self-checking bench for fdcr_regs: host model on the bus, core signals driven here.
 * Assumes a 250 MHz clock; results are compared in order by one monitor process.
 */
`timescale 1ns/1ns
`default_nettype none
module fdcr_rate_and_status_regs_tb;
	import fdcr_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cs_n, rd_n, wr_n, rd_done, poll_fail, data_oe;
	logic [2:0]  addr;
	logic [7:0]  wdata, data_o, rd_val, res_data_i = 8'h00;
	logic        adv_mode_i = 1'b0, dma_mode_i = 1'b0, cmd_last_i = 1'b0;
	logic        exec_req_i = 1'b0, exec_dir_i = 1'b0, recal_active_i = 1'b0;
	logic        step_pulse_i = 1'b0, track0_i = 1'b0, snap = 1'b0, snap_sel = 1'b0;
	logic [3:0]  drive_seeking_i = 4'h0;
	fdcr_end_s   end_i = '0;
	fdcr_byte_s  byte_o;
	fdcr_cfg_s   cfg_o;
	logic        res_pop_o, cmd_refused_o, bit_tick_o;
	logic [15:0] gap = 16'h0000;
	logic [15:0] exp_q[$];
	int          mismatches = 0;
	int          n_compared = 0;
	int          cyc = 0;
	wire  [15:0] cfg_v = {10'h000, cfg_o.rate, cfg_o.precomp_en, cfg_o.cfg_bit2};
	logic        oe_q = 1'b0;
	logic [4:0]  rw_ops [4] = '{OPC_WRITE_DATA, OPC_READ_DATA, OPC_WRITE_DEL, OPC_READ_DEL};
	always #2 clk_i = ~clk_i;
	fdcr_host h (.clk(clk_i), .rdata(data_o), .cs_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
		.wdata(wdata), .rd_done(rd_done), .rd_val(rd_val), .poll_fail(poll_fail));
	fdcr_regs DUT (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .addr_i(addr), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .data_i(wdata), .data_o(data_o), .data_oe_o(data_oe), .adv_mode_i(adv_mode_i),
		.dma_mode_i(dma_mode_i), .drive_seeking_i(drive_seeking_i), .cmd_last_i(cmd_last_i),
		.exec_req_i(exec_req_i), .exec_dir_i(exec_dir_i), .end_i(end_i), .res_data_i(res_data_i),
		.recal_active_i(recal_active_i), .step_pulse_i(step_pulse_i), .track0_i(track0_i),
		.byte_o(byte_o), .res_pop_o(res_pop_o), .cmd_refused_o(cmd_refused_o), .cfg_o(cfg_o),
		.bit_tick_o(bit_tick_o));
	task automatic cmp(input logic [15:0] got);
		logic [15:0] e;
		n_compared++;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
		if (got !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, e);
		end
	endtask
	always @(posedge clk_i) begin
		if (rd_done === 1'b1)
			cmp({7'h00, oe_q, rd_val});
		if (res_pop_o === 1'b1)
			cmp(16'h0F00);
		oe_q <= data_oe;
		if (byte_o.valid === 1'b1)
			cmp({7'h00, byte_o.first, byte_o.data});
		if (cmd_refused_o === 1'b1)
			cmp(16'h0E00);
		if (snap === 1'b1)
			cmp(snap_sel ? gap : cfg_v);
	end
	task automatic give_verdict();
		if (poll_fail === 1'b1 || exp_q.size() != 0)
			mismatches++;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic take_snap(input logic sel, input logic [15:0] want);
		exp_q.push_back(want);
		snap_sel <= sel;
		snap <= 1'b1;
		@(posedge clk_i);
		snap <= 1'b0;
	endtask
	task automatic tick_gap(input int want);
		int n;
		n = 0;
		@(posedge clk_i iff bit_tick_o === 1'b1);
		do begin
			@(posedge clk_i);
			n++;
		end while (bit_tick_o !== 1'b1 && n < 5000);
		gap = n[15:0];
		take_snap(1'b1, want[15:0]);
	endtask
	function automatic fdcr_rate_e rate_of(input logic [1:0] c);
		return c == 2'h0 ? RATE_500K : c == 2'h1 ? RATE_300K : c == 2'h2 ? RATE_250K : RATE_125K;
	endfunction
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] want);
		logic [7:0] v;
		exp_q.push_back({7'h00, (a == ADDR_MSR) | (a == ADDR_DATA), want});
		h.rd(a, 1'b1, v);
	endtask
	task automatic trip(input logic [7:0] op, input logic busy, input logic [7:0] xmsr, input fdcr_end_s e,
		input logic [7:0] st0);
		logic [7:0] r;
		h.poll(1'b0);
		exp_q.push_back({8'h01, op});
		h.wr(ADDR_DATA, op);
		h.poll(1'b0);
		rd_chk(ADDR_MSR, {busy, 4'h0} | 8'h80);
		exp_q.push_back({8'h00, 5'h00, e.head, e.unit});
		h.wr(ADDR_DATA, {5'h00, e.head, e.unit});
		cmd_last_i <= 1'b1;
		@(posedge clk_i);
		cmd_last_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rd_chk(ADDR_MSR, xmsr);
		if (op == 8'h07) begin
			recal_active_i <= 1'b1;
			repeat (255) begin
				@(posedge clk_i);
				step_pulse_i <= 1'b1;
				@(posedge clk_i);
				step_pulse_i <= 1'b0;
			end
		end
		r = 8'($urandom());
		res_data_i <= r;
		end_i <= e;
		@(posedge clk_i);
		end_i <= '0;
		h.poll(1'b1);
		rd_chk(ADDR_MSR, {busy, 4'h0} | 8'hC0);
		rd_chk(ADDR_DATA, st0);
		h.poll(1'b1);
		exp_q.push_back(16'h0F00);
		rd_chk(ADDR_DATA, r);
		h.poll(1'b0);
		rd_chk(ADDR_MSR, 8'h80);
		recal_active_i <= 1'b0;
	endtask
	initial begin
		logic [7:0] d;
		fdcr_rate_e w;
		logic [3:0] sk;
		logic [1:0] x;
		void'($urandom(32'hEE3B));
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		take_snap(1'b0, {10'h000, RATE_500K, 2'b10});
		rd_chk(ADDR_MSR, 8'h80);
		tick_gap(2000 / CLK_PERIOD_NS);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom());
			d[2:0] = i[2:0];
			d[4] = i[3] ^ d[5];
			adv_mode_i <= i[3];
			w = i[3] ? (d[1:0] == 2'h0 ? RATE_500K : RATE_250K) : rate_of(d[1:0]);
			h.wr(ADDR_RATE_CFG, d);
			take_snap(1'b0, {10'h000, w, i[3] ? ~d[4] : ~d[2], i[3] ? 1'b1 : d[2]});
			h.wr(3'h6, ~d);
			take_snap(1'b0, {10'h000, w, i[3] ? ~d[4] : ~d[2], i[3] ? 1'b1 : d[2]});
		end
		adv_mode_i <= 1'b0;
		h.wr(ADDR_RATE_CFG, 8'h02);
		tick_gap(4000 / CLK_PERIOD_NS);
		$display("test rate done");
		x = 2'($urandom());
		sk = 4'($urandom_range(15, 1));
		drive_seeking_i <= sk;
		h.poll(1'b0);
		exp_q.push_back(16'h0E00);
		h.wr(ADDR_DATA, {3'h0, rw_ops[x]});
		h.poll(1'b0);
		rd_chk(ADDR_MSR, {4'h8, sk});
		drive_seeking_i <= 4'h0;
		$display("test refuse done");
		x = 2'($urandom());
		exec_req_i <= x[1];
		exec_dir_i <= x[0];
		trip({3'h2, OPC_READ_DATA}, 1'b1, {x, 6'h30}, '{1'b1, 1'b1, 1'b0, 1'b1, 2'h2, 3'h1}, 8'h46);
		x = 2'($urandom());
		dma_mode_i <= 1'b1;
		exec_req_i <= x[1];
		exec_dir_i <= x[0];
		trip({3'h0, OPC_WRITE_DATA}, 1'b1, {x, 6'h10}, '{1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 3'h1}, 8'h04);
		x = 2'($urandom());
		dma_mode_i <= 1'b0;
		exec_req_i <= x[1];
		exec_dir_i <= x[0];
		trip(8'h07, 1'b0, {x, 6'h20}, '{1'b1, 1'b1, 1'b1, 1'b0, 2'h1, 3'h1}, 8'h71);
		$display("test command done");
		repeat (4) @(posedge clk_i);
		give_verdict();
	end
endmodule
`default_nettype wire
